//--- design/memmap_pkg.sv
package memmap_pkg;

  // ----------------------------------------
  // Register bus map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BANK = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam int CTRL_ROM_EN_BIT = 1;
  localparam int CTRL_ISP_BIT = 2;
  localparam logic RST_ROM_EN = 1'b1;
  localparam logic [1:0] RST_CODE_BANK = 2'h0;
  localparam logic [1:0] RST_WORK_BANK = 2'h0;
  localparam logic [1:0] ISP_PINS = 2'h3;
  localparam logic [1:0] BANK_ONE = 2'h1;

  // ----------------------------------------
  // Program space
  // ----------------------------------------
  localparam logic [15:0] CODE_BANKED_BASE = 16'h8000;
  localparam logic [15:0] CODE_ROM_BASE = 16'hFC00;
  localparam logic [17:0] PHYS_BANK1_BASE = 18'h10000;
  localparam logic [17:0] PHYS_ROM_BASE = 18'h20000;

  // ----------------------------------------
  // Data space
  // ----------------------------------------
  localparam logic [15:0] XD_RAM_END = 16'h1FFF;
  localparam logic [15:0] XD_MACR_END = 16'h21FF;
  localparam logic [15:0] XD_PHY_END = 16'h22FF;
  localparam logic [15:0] XD_MACM_END = 16'h24FF;
  localparam logic [15:0] XD_PERI_END = 16'h27FF;

  // ----------------------------------------
  // Internal register space
  // ----------------------------------------
  localparam logic [7:0] GPR_BIT_BASE = 8'h20;
  localparam logic [7:0] GPR_DATA_BASE = 8'h30;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam int PSW_RS_LSB = 3;

  typedef enum logic [3:0] {
    IK_DIRECT = 4'h1,
    IK_INDIRECT = 4'h2,
    IK_WORKREG = 4'h4,
    IK_BIT = 4'h8
  } int_kind_t;

  typedef struct packed {
    logic app_ram;
    logic mac_regs;
    logic phy_regs;
    logic mac_mem;
    logic periph_regs;
    logic unmapped;
  } xdata_sel_t;

  typedef struct packed {
    logic reg_bank;
    logic bit_area;
    logic data_ram;
    logic special_function_space;
    logic unmapped;
  } int_sel_t;

endpackage

//--- design/memmap_decoder.sv
`timescale 1ns/100ps
module memmap_decoder
  import memmap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [1:0] mode_select_pins,
  input wire logic [7:0] processor_status_word,
  input wire logic code_req,
  input wire logic [15:0] code_addr,
  output logic code_valid,
  output logic code_rom_sel,
  output logic [17:0] code_phys_addr,
  input wire logic xdata_req,
  input wire logic xdata_wr,
  input wire logic [15:0] xdata_addr,
  input wire logic [7:0] xdata_rdata_in,
  output logic xdata_valid,
  output logic xdata_wr_en,
  output memmap_pkg::xdata_sel_t xdata_sel,
  output logic [7:0] xdata_rdata,
  input wire logic int_req,
  input wire memmap_pkg::int_kind_t int_kind,
  input wire logic [7:0] int_addr,
  output logic int_valid,
  output memmap_pkg::int_sel_t int_sel,
  output logic [7:0] int_byte_addr,
  output logic [2:0] int_bit_pos,
  output logic int_bit_op
);
  import memmap_pkg::*;

  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic rom_en_ff, isp_ff;
  logic [1:0] code_bank_ff, work_bank_ff;
  logic [1:0] pins_meta_ff, pins_sync_ff;

  // One wait state: the answer comes on the second access cycle
  wire access = psel && penable;
  wire done = access && pready_ff;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_bank = paddr == OFS_BANK;
  wire hit_stat = paddr == OFS_STAT;
  wire hit_any = hit_ctrl || hit_bank || hit_stat;
  wire wr_ctrl = done && pwrite && hit_ctrl;
  wire wr_bank = done && pwrite && hit_bank;
  wire [31:0] rd_ctrl = {29'h0, isp_ff, rom_en_ff, 1'b0};
  wire [31:0] rd_bank = {30'h0, code_bank_ff};
  wire [31:0] rd_stat = {28'h0, pins_sync_ff, work_bank_ff};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_bank ? rd_bank : hit_stat ? rd_stat : 32'h0;
  wire nxt_pready = access && !pready_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pready && !hit_any;
      prdata_ff <= (nxt_pready && !pwrite) ? rd_mux : 32'h0;
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  // Mode pins are asynchronous; only the second stage is read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_meta_ff <= 2'h0;
      pins_sync_ff <= 2'h0;
      isp_ff <= 1'b0;
      rom_en_ff <= RST_ROM_EN;
      code_bank_ff <= RST_CODE_BANK;
      work_bank_ff <= RST_WORK_BANK;
    end
    else
    begin
      pins_meta_ff <= mode_select_pins;
      pins_sync_ff <= pins_meta_ff;
      isp_ff <= pins_sync_ff == ISP_PINS;
      if (wr_ctrl)
        rom_en_ff <= pwdata[CTRL_ROM_EN_BIT];
      if (wr_bank)
        code_bank_ff <= pwdata[1:0];
      work_bank_ff <= processor_status_word[PSW_RS_LSB +: 2];
    end
  end

  // ----------------------------------------
  // Program space decode
  // ----------------------------------------
  // Values 2 and 3 behave as bank zero so a stray write cannot hang fetches
  wire bank1 = code_bank_ff == BANK_ONE;
  wire in_banked = code_addr >= CODE_BANKED_BASE;
  wire in_rom = rom_en_ff && (code_addr >= CODE_ROM_BASE);
  wire [17:0] flash_lin = {2'h0, code_addr};
  wire [17:0] flash_b1 = PHYS_BANK1_BASE | {3'h0, code_addr[14:0]};
  wire [17:0] flash_addr = (in_banked && bank1) ? flash_b1 : flash_lin;
  wire [17:0] rom_addr = PHYS_ROM_BASE | {8'h0, code_addr[9:0]};
  wire [17:0] nxt_code_phys = in_rom ? rom_addr : flash_addr;

  logic code_valid_ff, code_rom_ff;
  logic [17:0] code_phys_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_valid_ff <= 1'b0;
      code_rom_ff <= 1'b0;
      code_phys_ff <= 18'h0;
    end
    else
    begin
      code_valid_ff <= code_req;
      code_rom_ff <= code_req && in_rom;
      code_phys_ff <= code_req ? nxt_code_phys : 18'h0;
    end
  end

  assign code_valid = code_valid_ff;
  assign code_rom_sel = code_rom_ff;
  assign code_phys_addr = code_phys_ff;

  // ----------------------------------------
  // Data space decode
  // ----------------------------------------
  xdata_sel_t nxt_xsel;
  assign nxt_xsel.app_ram = xdata_addr <= XD_RAM_END;
  assign nxt_xsel.mac_regs = !nxt_xsel.app_ram && xdata_addr <= XD_MACR_END;
  assign nxt_xsel.phy_regs = xdata_addr > XD_MACR_END && xdata_addr <= XD_PHY_END;
  assign nxt_xsel.mac_mem = xdata_addr > XD_PHY_END && xdata_addr <= XD_MACM_END;
  assign nxt_xsel.periph_regs = xdata_addr > XD_MACM_END && xdata_addr <= XD_PERI_END;
  assign nxt_xsel.unmapped = xdata_addr > XD_PERI_END;

  logic xdata_valid_ff, xdata_wr_ff;
  xdata_sel_t xdata_sel_ff;
  logic [7:0] xdata_rdata_ff;

  // Read data is passed one cycle after the select, masked when unmapped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xdata_valid_ff <= 1'b0;
      xdata_wr_ff <= 1'b0;
      xdata_sel_ff <= '0;
      xdata_rdata_ff <= 8'h00;
    end
    else
    begin
      xdata_valid_ff <= xdata_req;
      xdata_wr_ff <= xdata_req && xdata_wr && !nxt_xsel.unmapped;
      xdata_sel_ff <= xdata_req ? nxt_xsel : '0;
      xdata_rdata_ff <= xdata_sel_ff.unmapped ? 8'h00 : xdata_rdata_in;
    end
  end

  assign xdata_valid = xdata_valid_ff;
  assign xdata_wr_en = xdata_wr_ff;
  assign xdata_sel = xdata_sel_ff;
  assign xdata_rdata = xdata_rdata_ff;

  // ----------------------------------------
  // Internal register space decode
  // ----------------------------------------
  // Indirect access never reaches the SFRs; direct from 0x80 does
  wire is_bit = int_kind == IK_BIT;
  wire bit_sfr = is_bit && int_addr[7];
  wire [7:0] bit_byte_gpr = GPR_BIT_BASE | {4'h0, int_addr[6:3]};
  wire [7:0] bit_byte_sfr = {int_addr[7:3], 3'h0};
  wire [7:0] wreg_addr = {3'h0, work_bank_ff, int_addr[2:0]};
  wire [7:0] byte_addr = is_bit ? (bit_sfr ? bit_byte_sfr : bit_byte_gpr) :
                         (int_kind == IK_WORKREG) ? wreg_addr : int_addr;
  wire hi_half = byte_addr >= SFR_BASE;
  wire kind_ok = int_kind == IK_DIRECT || int_kind == IK_INDIRECT ||
                 int_kind == IK_WORKREG || is_bit;

  int_sel_t nxt_isel;
  assign nxt_isel.special_function_space = kind_ok && hi_half && int_kind != IK_INDIRECT;
  assign nxt_isel.unmapped = !kind_ok || (hi_half && int_kind == IK_INDIRECT);
  assign nxt_isel.reg_bank = kind_ok && byte_addr < GPR_BIT_BASE;
  assign nxt_isel.bit_area = kind_ok && byte_addr >= GPR_BIT_BASE &&
                             byte_addr < GPR_DATA_BASE;
  assign nxt_isel.data_ram = kind_ok && byte_addr >= GPR_DATA_BASE && !hi_half;

  logic int_valid_ff, int_bit_ff;
  int_sel_t int_sel_ff;
  logic [7:0] int_byte_ff;
  logic [2:0] int_pos_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_valid_ff <= 1'b0;
      int_bit_ff <= 1'b0;
      int_sel_ff <= '0;
      int_byte_ff <= 8'h00;
      int_pos_ff <= 3'h0;
    end
    else
    begin
      int_valid_ff <= int_req;
      int_bit_ff <= int_req && is_bit;
      int_sel_ff <= int_req ? nxt_isel : '0;
      int_byte_ff <= int_req ? byte_addr : 8'h00;
      int_pos_ff <= (int_req && is_bit) ? int_addr[2:0] : 3'h0;
    end
  end

  assign int_valid = int_valid_ff;
  assign int_sel = int_sel_ff;
  assign int_byte_addr = int_byte_ff;
  assign int_bit_pos = int_pos_ff;
  assign int_bit_op = int_bit_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rom_fetch;
    code_req && rom_en_ff && code_addr >= CODE_ROM_BASE;
  endsequence

  sequence s_rom_cleared;
    wr_ctrl && !pwdata[CTRL_ROM_EN_BIT];
  endsequence

  a_rom_overlay_route: assert property (s_rom_fetch |=> code_rom_sel &&
    code_phys_addr[17:10] == PHYS_ROM_BASE[17:10])
    else $error("overlay fetch not sent to rom");

  a_overlay_clear_flash: assert property (s_rom_cleared ##1 (code_req &&
    code_addr >= CODE_ROM_BASE && !wr_ctrl) |=> !code_rom_sel && code_valid)
    else $error("cleared overlay still selects rom");

  a_low_code_linear: assert property (code_req && code_addr < CODE_BANKED_BASE
    |=> code_phys_addr == {2'h0, $past(code_addr)})
    else $error("common area not linear");

  a_bank1_map: assert property (code_req && bank1 && code_addr >= CODE_BANKED_BASE &&
    !in_rom |=> code_phys_addr == (PHYS_BANK1_BASE | {3'h0, $past(code_addr[14:0])}))
    else $error("bank one mapping wrong");

  a_bank_bad_values: assert property (code_req && code_bank_ff[1] && !in_rom
    |=> code_phys_addr[17:16] == 2'h0)
    else $error("unused bank value left bank zero");

  a_xdata_onehot: assert property (xdata_valid |-> $onehot(xdata_sel))
    else $error("data select not one-hot");

  a_xdata_phy: assert property (xdata_req && xdata_addr[15:8] == 8'h22
    |=> xdata_sel.phy_regs)
    else $error("phy window not decoded");

  a_unmapped_quiet: assert property (xdata_req && xdata_addr > XD_PERI_END
    |=> !xdata_wr_en ##1 xdata_rdata == 8'h00)
    else $error("unmapped data access not ignored");

  a_isp_follow: assert property (pins_sync_ff == ISP_PINS [*2] |-> isp_ff)
    else $error("isp indication missed");

  a_isp_drop: assert property (pins_sync_ff != ISP_PINS |=> !isp_ff)
    else $error("isp indication stuck");

  a_workreg_bank: assert property (int_req && int_kind == IK_WORKREG
    |=> int_byte_addr[4:3] == $past(work_bank_ff) && int_sel.reg_bank)
    else $error("working register bank wrong");

  a_bit_gpr: assert property (int_req && is_bit && !int_addr[7]
    |=> int_sel.bit_area && int_byte_addr == (GPR_BIT_BASE | {4'h0, $past(int_addr[6:3])}))
    else $error("bit area address wrong");

  a_indirect_no_sfr: assert property (int_req && int_kind == IK_INDIRECT
    |=> !int_sel.special_function_space)
    else $error("indirect access reached sfr");

  a_sfr_bit_byte: assert property (int_req && is_bit && int_addr[7]
    |=> int_sel.special_function_space && int_byte_addr[2:0] == 3'h0)
    else $error("sfr bit address not aligned");

  a_data_ram_hit: assert property (int_req && int_kind == IK_DIRECT &&
    int_addr >= GPR_DATA_BASE && int_addr < SFR_BASE |=> int_sel.data_ram)
    else $error("general byte ram not decoded");

  a_bank0_linear: assert property (code_req && !bank1 && !in_rom
    |=> code_phys_addr == {2'h0, $past(code_addr)})
    else $error("bank zero mapping wrong");

  a_rom_offset: assert property (s_rom_fetch
    |=> code_phys_addr[9:0] == $past(code_addr[9:0]))
    else $error("rom offset wrong");

  a_xdata_ram: assert property (xdata_req && xdata_addr <= XD_RAM_END
    |=> xdata_sel.app_ram)
    else $error("application ram not decoded");

  a_xdata_mac_mem: assert property (xdata_req && xdata_addr > XD_PHY_END &&
    xdata_addr <= XD_MACM_END |=> xdata_sel.mac_mem)
    else $error("mac memory window not decoded");

  a_xdata_periph: assert property (xdata_req && xdata_addr > XD_MACM_END &&
    xdata_addr <= XD_PERI_END |=> xdata_sel.periph_regs)
    else $error("peripheral window not decoded");

endmodule

//--- bench/region_model.sv
`timescale 1ns/100ps
module region_model
  import memmap_pkg::*;
(
  input wire logic pclk,
  input wire memmap_pkg::xdata_sel_t xdata_sel,
  output logic [7:0] xdata_rdata_in
);
  // ----------------------------------------
  // Region read data
  // ----------------------------------------
  // Nothing selected: a toggling pattern, so stale data never passes as zero
  logic [7:0] idle_ff = 8'h5A;
  always @(posedge pclk)
  begin
    idle_ff <= ~idle_ff;
  end
  assign xdata_rdata_in = xdata_sel.app_ram ? 8'h11 :
    xdata_sel.mac_regs ? 8'h22 : xdata_sel.mac_mem ? 8'h44 :
    xdata_sel.phy_regs ? 8'h33 :
    xdata_sel.periph_regs ? 8'h55 : idle_ff;
endmodule

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import memmap_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic [1:0] mode_select_pins = 2'h0;
  logic [7:0] processor_status_word = 8'h00;
  logic code_req = 1'b0, code_valid, code_rom_sel;
  logic [15:0] code_addr = 16'h0;
  logic [17:0] code_phys_addr;
  logic xdata_req = 1'b0, xdata_wr = 1'b0, xdata_valid, xdata_wr_en;
  logic [15:0] xdata_addr = 16'h0;
  logic [7:0] xdata_rdata_in, xdata_rdata, int_addr = 8'h00, int_byte_addr;
  xdata_sel_t xdata_sel;
  logic int_req = 1'b0, int_valid, int_bit_op;
  int_kind_t int_kind = IK_DIRECT;
  int_sel_t int_sel;
  logic [2:0] int_bit_pos;
  int errors = 0;
  int num_checks = 0;
  memmap_decoder memmap_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .mode_select_pins(mode_select_pins),
    .processor_status_word(processor_status_word), .code_req(code_req),
    .code_addr(code_addr), .code_valid(code_valid), .code_rom_sel(code_rom_sel),
    .code_phys_addr(code_phys_addr), .xdata_req(xdata_req), .xdata_wr(xdata_wr),
    .xdata_addr(xdata_addr), .xdata_rdata_in(xdata_rdata_in), .xdata_valid(xdata_valid),
    .xdata_wr_en(xdata_wr_en), .xdata_sel(xdata_sel), .xdata_rdata(xdata_rdata),
    .int_req(int_req), .int_kind(int_kind), .int_addr(int_addr), .int_valid(int_valid),
    .int_sel(int_sel), .int_byte_addr(int_byte_addr), .int_bit_pos(int_bit_pos),
    .int_bit_op(int_bit_op));
  region_model region_model_inst (.pclk(pclk), .xdata_sel(xdata_sel),
    .xdata_rdata_in(xdata_rdata_in));
  initial
  begin
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Holds the request until pready is sampled high; the answer is taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      chk("pready", pready, 1'b1);
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fetch(input logic [15:0] a, input logic rom, input logic [17:0] ph);
    @(posedge pclk);
    code_req <= 1'b1;
    code_addr <= a;
    @(posedge pclk);
    code_req <= 1'b0;
    @(negedge pclk);
    chk("code_valid", code_valid, 1'b1);
    chk("code_rom_sel", code_rom_sel, rom);
    chk("code_phys_addr", code_phys_addr, ph);
  endtask
  task automatic xd(input logic [15:0] a, input logic w, input logic [5:0] s,
    input logic [7:0] d);
    @(posedge pclk);
    xdata_req <= 1'b1;
    xdata_wr <= w;
    xdata_addr <= a;
    @(posedge pclk);
    xdata_req <= 1'b0;
    @(negedge pclk);
    chk("xdata_valid", xdata_valid, 1'b1);
    chk("xdata_sel", {26'h0, xdata_sel}, s);
    chk("xdata_wr_en", xdata_wr_en, w & ~s[0]);
    @(negedge pclk);
    if (!w) chk("xdata_rdata", xdata_rdata, d);
  endtask
  task automatic ir(input int_kind_t k, input logic [7:0] a, input logic [4:0] s,
    input logic [7:0] b, input logic [2:0] p);
    @(posedge pclk);
    int_req <= 1'b1;
    int_kind <= k;
    int_addr <= a;
    @(posedge pclk);
    int_req <= 1'b0;
    @(negedge pclk);
    chk("int_valid", int_valid, 1'b1);
    chk("int_sel", {27'h0, int_sel}, s);
    if (!s[0]) chk("int_byte_addr", int_byte_addr, b);
    chk("int_bit_op", int_bit_op, k == IK_BIT);
    if (k == IK_BIT) chk("int_bit_pos", int_bit_pos, p);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_program();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h2);
    fetch(16'hFC00, 1'b1, 18'h20000);
    fetch(16'hFFFF, 1'b1, 18'h203FF);
    fetch(16'hFBFF, 1'b0, 18'h0FBFF);
    apb(1'b1, OFS_BANK, 32'h1);
    fetch(16'h8000, 1'b0, 18'h10000);
    fetch(16'h7FFF, 1'b0, 18'h07FFF);
    apb(1'b1, OFS_CTRL, 32'h0);
    fetch(16'hFC00, 1'b0, 18'h17C00);
    apb(1'b1, OFS_BANK, 32'h2);
    fetch(16'h8000, 1'b0, 18'h08000);
    apb(1'b0, 8'h0C, 32'h0);
    chk("pslverr", er, 1'b1);
    $display("test program done");
  endtask
  task automatic t_data();
    xd(16'h0000, 1'b0, 6'h20, 8'h11);
    xd(16'h1FFF, 1'b1, 6'h20, 8'h00);
    xd(16'h2000, 1'b0, 6'h10, 8'h22);
    xd(16'h21FF, 1'b0, 6'h10, 8'h22);
    xd(16'h2200, 1'b0, 6'h08, 8'h33);
    xd(16'h22FF, 1'b1, 6'h08, 8'h00);
    xd(16'h2300, 1'b0, 6'h04, 8'h44);
    xd(16'h24FF, 1'b0, 6'h04, 8'h44);
    xd(16'h2500, 1'b0, 6'h02, 8'h55);
    xd(16'h27FF, 1'b0, 6'h02, 8'h55);
    xd(16'h2800, 1'b0, 6'h01, 8'h00);
    xd(16'hFFFF, 1'b1, 6'h01, 8'h00);
    $display("test data done");
  endtask
  task automatic t_internal();
    ir(IK_WORKREG, 8'h03, 5'h10, 8'h03, 3'h0);
    @(posedge pclk);
    processor_status_word <= 8'h10;
    repeat (3) @(posedge pclk);
    ir(IK_WORKREG, 8'h03, 5'h10, 8'h13, 3'h0);
    ir(IK_INDIRECT, 8'h08, 5'h10, 8'h08, 3'h0);
    ir(IK_BIT, 8'h0A, 5'h08, 8'h21, 3'h2);
    ir(IK_BIT, 8'h83, 5'h02, 8'h80, 3'h3);
    ir(IK_DIRECT, 8'h2F, 5'h08, 8'h2F, 3'h0);
    ir(IK_INDIRECT, 8'h40, 5'h04, 8'h40, 3'h0);
    ir(IK_DIRECT, 8'h7F, 5'h04, 8'h7F, 3'h0);
    ir(IK_INDIRECT, 8'h90, 5'h01, 8'h00, 3'h0);
    ir(IK_DIRECT, 8'h90, 5'h02, 8'h90, 3'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("stat bank", rd, 32'h2);
    $display("test internal done");
  endtask
  task automatic t_isp();
    mode_select_pins <= 2'h3;
    repeat (5) @(posedge pclk);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("isp set", rd, 32'h4);
    mode_select_pins <= 2'h2;
    repeat (5) @(posedge pclk);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("isp clear", rd, 32'h0);
    $display("test isp done");
  endtask
  // Mid-run reset after the control bits were changed; a fetch is held high across
  // the overlay clear so the fetch right after the write sees the new routing
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    processor_status_word <= 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl after reset", rd, 32'h2);
    apb(1'b0, OFS_BANK, 32'h0);
    chk("bank after reset", rd, 32'h0);
    ir(IK_WORKREG, 8'h05, 5'h10, 8'h05, 3'h0);
    @(posedge pclk);
    code_req <= 1'b1;
    code_addr <= 16'hFC00;
    apb(1'b1, OFS_CTRL, 32'h0);
    fetch(16'hFC00, 1'b0, 18'h0FC00);
    $display("test reset done");
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_program();
    t_data();
    t_internal();
    t_isp();
    t_reset();
    complete_run();
  end
endmodule
